// *** lsc_list_consts.svh ***
// constants for the list-sweep slot configuration block: offsets, limits, reset values, widths
`ifndef LSC_LIST_CONSTS_SVH
`define LSC_LIST_CONSTS_SVH

// register byte offsets on the AHB-Lite slave
`define LSC_OFF_ENABLE 8'h00
`define LSC_OFF_POINTS 8'h04
`define LSC_OFF_SLOTS 8'h08
`define LSC_OFF_SLOT_TIME 8'h0C
`define LSC_OFF_EXCL_OFF 8'h10
`define LSC_OFF_EXCL_LEN 8'h14
`define LSC_OFF_GATE_START 8'h18
`define LSC_OFF_MODE 8'h1C
`define LSC_OFF_COUPLED 8'h20
`define LSC_OFF_READINGS 8'h24
`define LSC_OFF_ERROR 8'h28
`define LSC_OFF_IRQ_STATUS 8'h2C
`define LSC_OFF_IRQ_MASK 8'h30
`define LSC_OFF_FREQ_STEP 8'h34

// field widths
`define LSC_PTS_W 13
`define LSC_SLOTS_W 5
`define LSC_SLOT_W 27
`define LSC_EXCL_W 23
`define LSC_PCT_W 10
`define LSC_FREQ_W 30
`define LSC_READ_W 17

// mode and coupled-feature bit positions
`define LSC_MODE_TRIG_EXT 0
`define LSC_MODE_DET_AVG 1
`define LSC_CPL_TRACE 4
`define LSC_CPL_CCDF_CONT 5
`define LSC_CPL_CCDF_SWEEP 6

// interrupt status bits
`define LSC_IRQ_CLIP 0
`define LSC_IRQ_CONFLICT 1

// error codes, two's complement of -222 and -221
`define LSC_ERR_CLIPPED 32'hFFFF_FF22
`define LSC_ERR_CONFLICT 32'hFFFF_FF23

// numeric limits
`define LSC_POINTS_MIN 32'h0000_0001
`define LSC_POINTS_MAX 32'h0000_1000
`define LSC_SLOTS_MIN 32'h0000_0001
`define LSC_SLOTS_MAX 32'h0000_0010
`define LSC_PCT_MAX 32'h0000_03E8

// times: resolution tick, write unit, limits in their own units
`define LSC_TICK_PS 64'd12500
`define LSC_WR_UNIT_PS 64'd1250
`define LSC_SLOT_MAX_S 64'd1
`define LSC_EXCL_MAX_MS 64'd100
`define LSC_WR_PER_TICK (`LSC_TICK_PS / `LSC_WR_UNIT_PS)
`define LSC_SLOT_MAX_TICKS (`LSC_SLOT_MAX_S * 64'd1000000000000 / `LSC_TICK_PS)
`define LSC_EXCL_MAX_TICKS (`LSC_EXCL_MAX_MS * 64'd1000000000 / `LSC_TICK_PS)
`define LSC_CAPTURE_MAX_TICKS `LSC_SLOT_MAX_TICKS
`define LSC_PCT_WR_PER_STEP 64'd10

// reset values
`define LSC_POINTS_RST 13'h0001
`define LSC_SLOTS_RST 5'h01
`define LSC_SLOT_RST 27'h000_0001
`define LSC_READ_RST 17'h0_0001

// divider walks one quotient bit per cycle
`define LSC_DV_LAST 5'h1D

`endif

// *** lsc_pkg.sv ***
// types for the list-sweep slot configuration block
`include "lsc_list_consts.svh"

package lsc_pkg;

    typedef enum logic {
        LSC_DV_IDLE = 1'b0,
        LSC_DV_RUN = 1'b1
    } lsc_dv_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hready;
        logic hresp;
        logic irq;
        logic dp_write;
        logic [7:0] dp_addr;
        logic list_en;
        logic [`LSC_PTS_W-1:0] points;
        logic [`LSC_SLOTS_W-1:0] slots;
        logic [`LSC_SLOT_W-1:0] slot_ticks;
        logic [`LSC_EXCL_W-1:0] excl_off;
        logic [`LSC_EXCL_W-1:0] excl_len;
        logic [`LSC_PCT_W-1:0] gate_start;
        logic trig_ext;
        logic det_avg;
        logic [3:0] gate_auto;
        logic trace_en;
        logic ccdf_cont;
        logic ccdf_sweep;
        logic [`LSC_READ_W-1:0] readings;
        logic [31:0] err_code;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        lsc_dv_t dv_state;
        logic [4:0] dv_cnt;
        logic [`LSC_PTS_W:0] dv_rem;
        logic [`LSC_FREQ_W-1:0] dv_quo;
        logic [`LSC_PTS_W-1:0] dv_den;
        logic [`LSC_FREQ_W-1:0] freq_step;
    } lsc_state_t;

endpackage : lsc_pkg

// *** lsc_list_config.sv ***
// list-sweep slot configuration: settings, interlocks, error log and reading count behind AHB-Lite
// How it works
// - point count 1..4096, resets to 1
// - frequency step equals span over points minus one
// - out-of-range value clipped, error -222 logged
// - list writes refused while sequence runs, -221
// - list enable cleared on reset, reads 1/0
// - enable write needs external trigger, else -221
// - enabling under normal detector forces couplings off
// - slots per burst 1..16, resets to 1
// - readings returned equal slots times points
// - slot settings refused under average detector
// - slot time times slots over 1 s refused
// - exclusion offset 0..0.1 s, 12.5 ns steps
// - exclusion length 0..0.1 s, 12.5 ns steps
// - slot duration 12.5 ns..1 s, normal detector
// - gate start 0..100.0 percent, 0.1 steps
// - point and slot counts read as integers
//
// The placing of the registers and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "lsc_list_consts.svh"

module lsc_list_config (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic SEQ_RUNNING,
    input wire logic [`LSC_FREQ_W-1:0] FREQ_START,
    input wire logic [`LSC_FREQ_W-1:0] FREQ_STOP,
    output logic IRQ,
    output logic LIST_ENABLE,
    output logic [`LSC_PTS_W-1:0] SWEEP_POINT_COUNT,
    output logic [`LSC_SLOTS_W-1:0] SLOTS_PER_BURST,
    output logic [`LSC_SLOT_W-1:0] SLOT_DURATION,
    output logic [`LSC_EXCL_W-1:0] EXCLUSION_OFFSET,
    output logic [`LSC_EXCL_W-1:0] EXCLUSION_LENGTH,
    output logic [`LSC_PCT_W-1:0] GATE_START_PERCENT,
    output logic [`LSC_READ_W-1:0] READING_COUNT,
    output logic [`LSC_FREQ_W-1:0] FREQ_STEP,
    output logic [3:0] GATE_AUTO_GATING,
    output logic TRACE_DISPLAY_ENABLE,
    output logic CCDF_CONTINUOUS,
    output logic CCDF_SWEEP_ENABLE
);

    lsc_pkg::lsc_state_t s;
    lsc_pkg::lsc_state_t next_s;

    // clip to [lo, hi]; top bit flags that clipping happened
    function automatic logic [32:0] lsc_clip(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
        logic [32:0] r;
        r = {1'b0, v};
        if (v < lo) begin
            r = {1'b1, lo};
        end else if (v > hi) begin
            r = {1'b1, hi};
        end
        return r;
    endfunction : lsc_clip

    // value over the step, rounded to the nearest whole step; 33 bits so a huge write cannot wrap
    function automatic logic [31:0] lsc_round(input logic [31:0] v, input logic [32:0] step);
        logic [32:0] t;
        t = ({1'b0, v} + (step >> 1)) / step;
        return t[31:0];
    endfunction : lsc_round

    // next-state logic: bus phases, setting writes, interlocks, divider, read mux
    always_comb begin
        logic addr_take;
        logic is_list;
        logic conflict;
        logic clipped;
        logic [31:0] wv;
        logic [32:0] c;
        logic [31:0] prod;
        logic [`LSC_FREQ_W-1:0] span;
        logic [`LSC_PTS_W:0] rem_sh;
        logic [`LSC_FREQ_W-1:0] q_next;
        logic [31:0] rd;
        addr_take = 1'b0;
        is_list = 1'b0;
        conflict = 1'b0;
        clipped = 1'b0;
        wv = HWDATA;
        c = 33'h0_0000_0000;
        prod = 32'h0000_0000;
        span = '0;
        rem_sh = '0;
        q_next = '0;
        rd = 32'h0000_0000;
        next_s = s;

        // zero-wait slave: every transfer completes with OKAY
        next_s.hready = 1'b1;
        next_s.hresp = 1'b0;
        addr_take = HSEL & HTRANS[1] & HREADY;
        next_s.dp_write = addr_take & HWRITE;
        next_s.dp_addr = HADDR[7:0];

        // data phase of a write
        is_list = (s.dp_addr == `LSC_OFF_ENABLE) || (s.dp_addr == `LSC_OFF_POINTS) ||
            (s.dp_addr == `LSC_OFF_SLOTS) || (s.dp_addr == `LSC_OFF_SLOT_TIME) ||
            (s.dp_addr == `LSC_OFF_EXCL_OFF) || (s.dp_addr == `LSC_OFF_EXCL_LEN) ||
            (s.dp_addr == `LSC_OFF_GATE_START);
        if (s.dp_write) begin
            if (s.dp_addr == `LSC_OFF_MODE) begin
                next_s.trig_ext = wv[`LSC_MODE_TRIG_EXT];
                next_s.det_avg = wv[`LSC_MODE_DET_AVG];
            end else if (s.dp_addr == `LSC_OFF_COUPLED) begin
                next_s.gate_auto = wv[3:0];
                next_s.trace_en = wv[`LSC_CPL_TRACE];
                next_s.ccdf_cont = wv[`LSC_CPL_CCDF_CONT];
                next_s.ccdf_sweep = wv[`LSC_CPL_CCDF_SWEEP];
            end else if (s.dp_addr == `LSC_OFF_IRQ_MASK) begin
                next_s.irq_mask = wv[1:0];
            end else if (is_list && SEQ_RUNNING) begin
                conflict = 1'b1;
            end else if (s.dp_addr == `LSC_OFF_ENABLE) begin
                if (!s.trig_ext) begin
                    conflict = 1'b1;
                end else begin
                    next_s.list_en = wv[0];
                    // couplings that cannot coexist with a list sweep
                    if (wv[0] && !s.det_avg) begin
                        next_s.gate_auto = 4'h0;
                        next_s.trace_en = 1'b0;
                        next_s.ccdf_cont = 1'b0;
                        next_s.ccdf_sweep = 1'b0;
                    end
                end
            end else if (s.dp_addr == `LSC_OFF_POINTS) begin
                c = lsc_clip(wv, `LSC_POINTS_MIN, `LSC_POINTS_MAX);
                next_s.points = c[`LSC_PTS_W-1:0];
                clipped = c[32];
            end else if (is_list && s.det_avg) begin
                conflict = 1'b1;
            end else if (s.dp_addr == `LSC_OFF_SLOTS) begin
                c = lsc_clip(wv, `LSC_SLOTS_MIN, `LSC_SLOTS_MAX);
                prod = 32'(s.slot_ticks) * c[31:0];
                if (prod > 32'(`LSC_CAPTURE_MAX_TICKS)) begin
                    conflict = 1'b1;
                end else begin
                    next_s.slots = c[`LSC_SLOTS_W-1:0];
                    clipped = c[32];
                end
            end else if (s.dp_addr == `LSC_OFF_SLOT_TIME) begin
                // written in 1.25 ns units, held in 12.5 ns ticks
                c = lsc_clip(lsc_round(wv, 33'(`LSC_WR_PER_TICK)), 32'h0000_0001,
                    32'(`LSC_SLOT_MAX_TICKS));
                prod = c[31:0] * 32'(s.slots);
                if (prod > 32'(`LSC_CAPTURE_MAX_TICKS)) begin
                    conflict = 1'b1;
                end else begin
                    next_s.slot_ticks = c[`LSC_SLOT_W-1:0];
                    clipped = c[32];
                end
            end else if (s.dp_addr == `LSC_OFF_EXCL_OFF) begin
                c = lsc_clip(lsc_round(wv, 33'(`LSC_WR_PER_TICK)), 32'h0000_0000,
                    32'(`LSC_EXCL_MAX_TICKS));
                next_s.excl_off = c[`LSC_EXCL_W-1:0];
                clipped = c[32];
            end else if (s.dp_addr == `LSC_OFF_EXCL_LEN) begin
                c = lsc_clip(lsc_round(wv, 33'(`LSC_WR_PER_TICK)), 32'h0000_0000,
                    32'(`LSC_EXCL_MAX_TICKS));
                next_s.excl_len = c[`LSC_EXCL_W-1:0];
                clipped = c[32];
            end else if (s.dp_addr == `LSC_OFF_GATE_START) begin
                // written in 0.01 percent, held in 0.1 percent
                c = lsc_clip(lsc_round(wv, 33'(`LSC_PCT_WR_PER_STEP)), 32'h0000_0000,
                    `LSC_PCT_MAX);
                next_s.gate_start = c[`LSC_PCT_W-1:0];
                clipped = c[32];
            end
        end

        // error log keeps the latest code; conflict outranks clipping
        if (conflict) begin
            next_s.err_code = `LSC_ERR_CONFLICT;
        end else if (clipped) begin
            next_s.err_code = `LSC_ERR_CLIPPED;
        end

        // readings every fetch returns, kept in step with the settings
        next_s.readings = `LSC_READ_W'(next_s.points) * `LSC_READ_W'(next_s.slots);

        // step = |stop - start| / (points - 1), one quotient bit per cycle
        span = (FREQ_STOP >= FREQ_START) ? (FREQ_STOP - FREQ_START) : (FREQ_START - FREQ_STOP);
        case (s.dv_state)
            lsc_pkg::LSC_DV_IDLE: begin
                next_s.dv_quo = span;
                next_s.dv_den = s.points - `LSC_PTS_W'(1);
                next_s.dv_rem = '0;
                next_s.dv_cnt = 5'h00;
                if ((span == '0) || (s.points == `LSC_POINTS_RST)) begin
                    next_s.freq_step = '0;
                end else begin
                    next_s.dv_state = lsc_pkg::LSC_DV_RUN;
                end
            end
            lsc_pkg::LSC_DV_RUN: begin
                rem_sh = {s.dv_rem[`LSC_PTS_W-1:0], s.dv_quo[`LSC_FREQ_W-1]};
                if (rem_sh >= {1'b0, s.dv_den}) begin
                    next_s.dv_rem = rem_sh - {1'b0, s.dv_den};
                    q_next = {s.dv_quo[`LSC_FREQ_W-2:0], 1'b1};
                end else begin
                    next_s.dv_rem = rem_sh;
                    q_next = {s.dv_quo[`LSC_FREQ_W-2:0], 1'b0};
                end
                next_s.dv_quo = q_next;
                next_s.dv_cnt = s.dv_cnt + 5'h01;
                if (s.dv_cnt == `LSC_DV_LAST) begin
                    next_s.freq_step = q_next;
                    next_s.dv_state = lsc_pkg::LSC_DV_IDLE;
                end
            end
            default: begin
                next_s.dv_state = lsc_pkg::LSC_DV_IDLE;
            end
        endcase

        // events go in before any read so a read reports them
        if (conflict) begin
            next_s.irq_status[`LSC_IRQ_CONFLICT] = 1'b1;
        end
        if (clipped) begin
            next_s.irq_status[`LSC_IRQ_CLIP] = 1'b1;
        end

        // read mux from the updated copy, so a write just before is seen
        if (HADDR[7:0] == `LSC_OFF_ENABLE) begin
            rd = {31'h0, next_s.list_en};
        end else if (HADDR[7:0] == `LSC_OFF_POINTS) begin
            rd = 32'(next_s.points);
        end else if (HADDR[7:0] == `LSC_OFF_SLOTS) begin
            rd = 32'(next_s.slots);
        end else if (HADDR[7:0] == `LSC_OFF_SLOT_TIME) begin
            rd = 32'(next_s.slot_ticks);
        end else if (HADDR[7:0] == `LSC_OFF_EXCL_OFF) begin
            rd = 32'(next_s.excl_off);
        end else if (HADDR[7:0] == `LSC_OFF_EXCL_LEN) begin
            rd = 32'(next_s.excl_len);
        end else if (HADDR[7:0] == `LSC_OFF_GATE_START) begin
            rd = 32'(next_s.gate_start);
        end else if (HADDR[7:0] == `LSC_OFF_MODE) begin
            rd = {30'h0, next_s.det_avg, next_s.trig_ext};
        end else if (HADDR[7:0] == `LSC_OFF_COUPLED) begin
            rd = {25'h0, next_s.ccdf_sweep, next_s.ccdf_cont, next_s.trace_en, next_s.gate_auto};
        end else if (HADDR[7:0] == `LSC_OFF_READINGS) begin
            rd = 32'(next_s.readings);
        end else if (HADDR[7:0] == `LSC_OFF_ERROR) begin
            rd = next_s.err_code;
        end else if (HADDR[7:0] == `LSC_OFF_IRQ_STATUS) begin
            rd = {30'h0, next_s.irq_status};
        end else if (HADDR[7:0] == `LSC_OFF_IRQ_MASK) begin
            rd = {30'h0, next_s.irq_mask};
        end else if (HADDR[7:0] == `LSC_OFF_FREQ_STEP) begin
            rd = 32'(next_s.freq_step);
        end
        if (addr_take && !HWRITE) begin
            next_s.hrdata = rd;
            // reading the status or the error log empties it
            if (HADDR[7:0] == `LSC_OFF_IRQ_STATUS) begin
                next_s.irq_status = 2'h0;
            end
            if (HADDR[7:0] == `LSC_OFF_ERROR) begin
                next_s.err_code = 32'h0000_0000;
            end
        end
        next_s.irq = |(next_s.irq_status & next_s.irq_mask);
    end

    // single state register
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            s <= '0;
            s.hready <= 1'b1;
            s.points <= `LSC_POINTS_RST;
            s.slots <= `LSC_SLOTS_RST;
            s.slot_ticks <= `LSC_SLOT_RST;
            s.readings <= `LSC_READ_RST; // one point times one slot, so the count is right from the first edge
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state flops
    assign HRDATA = s.hrdata;
    assign HREADYOUT = s.hready;
    assign HRESP = s.hresp;
    assign IRQ = s.irq;
    assign LIST_ENABLE = s.list_en;
    assign SWEEP_POINT_COUNT = s.points;
    assign SLOTS_PER_BURST = s.slots;
    assign SLOT_DURATION = s.slot_ticks;
    assign EXCLUSION_OFFSET = s.excl_off;
    assign EXCLUSION_LENGTH = s.excl_len;
    assign GATE_START_PERCENT = s.gate_start;
    assign READING_COUNT = s.readings;
    assign FREQ_STEP = s.freq_step;
    assign GATE_AUTO_GATING = s.gate_auto;
    assign TRACE_DISPLAY_ENABLE = s.trace_en;
    assign CCDF_CONTINUOUS = s.ccdf_cont;
    assign CCDF_SWEEP_ENABLE = s.ccdf_sweep;

    // checks on settings, interlocks and error codes
    points_range_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        (s.points >= 13'h0001) && (s.points <= 13'h1000))
        else $error("point count out of range");

    clip_points_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        (s.dp_write && s.dp_addr == `LSC_OFF_POINTS && !SEQ_RUNNING && HWDATA == 32'h0)
        |=> (s.points == 13'h0001) && (s.err_code == `LSC_ERR_CLIPPED))
        else $error("zero point count not clipped to one");

    running_refuse_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        (s.dp_write && s.dp_addr == `LSC_OFF_POINTS && SEQ_RUNNING)
        |=> (s.points == $past(s.points)) && (s.err_code == `LSC_ERR_CONFLICT))
        else $error("write accepted while sequence running");

    trigger_refuse_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        (s.dp_write && s.dp_addr == `LSC_OFF_ENABLE && !s.trig_ext)
        |=> $stable(s.list_en) && (s.err_code == `LSC_ERR_CONFLICT))
        else $error("enable taken without external trigger");

    couple_off_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        ($rose(s.list_en) && !$past(s.det_avg))
        |-> (s.gate_auto == 4'h0) && !s.trace_en && !s.ccdf_cont && !s.ccdf_sweep)
        else $error("couplings left on after enable");

    slots_range_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        (s.slots >= 5'h01) && (s.slots <= 5'h10))
        else $error("slot count out of range");

    reading_count_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        s.readings == `LSC_READ_W'(s.points) * `LSC_READ_W'(s.slots))
        else $error("reading count mismatch");

    average_refuse_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        (s.dp_write && s.dp_addr == `LSC_OFF_GATE_START && s.det_avg && !SEQ_RUNNING)
        |=> $stable(s.gate_start) ##0 (s.err_code == `LSC_ERR_CONFLICT))
        else $error("gate start written under average detector");

    capture_limit_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        (32'(s.slot_ticks) * 32'(s.slots)) <= 32'h04C4_B400)
        else $error("capture buffer exceeds one second");

    excl_range_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        (s.excl_off <= 23'h7A_1200) && (s.excl_len <= 23'h7A_1200))
        else $error("exclusion window out of range");

    slot_time_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        s.slot_ticks != '0)
        else $error("slot duration below one tick");

    gate_pct_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        s.gate_start <= 10'h3E8)
        else $error("gate start above full slot");

endmodule : lsc_list_config

`default_nettype wire

// *** lsc_list_config_tb_top.sv ***
// self-checking bench for the list-sweep slot configuration block
`timescale 1ns/100ps
`default_nettype none
`include "lsc_list_consts.svh"

module lsc_list_config_tb_top;
    logic clk, rst, hsel, hwrite, hready, hresp, seq_running, irq, list_enable;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd, old;
    logic [`LSC_FREQ_W-1:0] freq_start, freq_stop, freq_step;
    logic [`LSC_READ_W-1:0] reading_count;
    logic [`LSC_PTS_W-1:0] point_count;
    logic [`LSC_SLOTS_W-1:0] slots_per_burst;
    logic [`LSC_SLOT_W-1:0] slot_duration;
    logic [`LSC_EXCL_W-1:0] excl_off, excl_len;
    logic [`LSC_PCT_W-1:0] gate_start;
    logic [3:0] gate_auto;
    logic trace_en, ccdf_cont, ccdf_sweep;
    logic [7:0] offs [5];
    int miscompares, compares;

    // hready loops back from the only slave on the bus
    lsc_list_config u_lsc_list_config (
        .CLK_SYS(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
        .HRESP(hresp), .SEQ_RUNNING(seq_running), .FREQ_START(freq_start), .FREQ_STOP(freq_stop),
        .IRQ(irq), .LIST_ENABLE(list_enable), .SWEEP_POINT_COUNT(point_count),
        .SLOTS_PER_BURST(slots_per_burst), .SLOT_DURATION(slot_duration), .EXCLUSION_OFFSET(excl_off),
        .EXCLUSION_LENGTH(excl_len), .GATE_START_PERCENT(gate_start),
        .READING_COUNT(reading_count), .FREQ_STEP(freq_step), .GATE_AUTO_GATING(gate_auto),
        .TRACE_DISPLAY_ENABLE(trace_en), .CCDF_CONTINUOUS(ccdf_cont), .CCDF_SWEEP_ENABLE(ccdf_sweep)
    );

    // 100 MHz system clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // one single transfer; the request stands until hready is seen high, read data taken at the next edge with hready high
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h000000, a};
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : xfer

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask : rchk

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    // cuts a hang short; the whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        summarize();
    end

    initial begin
        rst = 1'b1;
        hsel = 1'b1;
        hwrite = 1'b0;
        htrans = 2'b00;
        hsize = 3'h2;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        seq_running = 1'b0;
        freq_start = 30'h0000_03E8;
        freq_stop = 30'h0000_1388;
        offs = '{`LSC_OFF_SLOTS, `LSC_OFF_SLOT_TIME, `LSC_OFF_EXCL_OFF, `LSC_OFF_EXCL_LEN, `LSC_OFF_GATE_START};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // reset values and an unmapped place
        rchk(`LSC_OFF_ENABLE, 32'h0);
        rchk(`LSC_OFF_POINTS, 32'h1);
        rchk(`LSC_OFF_SLOTS, 32'h1);
        rchk(`LSC_OFF_READINGS, 32'h1);
        rchk(8'h3C, 32'h0);
        chk(32'(list_enable), 32'h0);
        chk(32'(hresp), 32'h0);
        chk(32'(point_count), 32'h1);
        $display("test reset done");
        // enable refused without external trigger, interrupt raised, cleared, then masked
        xfer(1'b1, `LSC_OFF_IRQ_MASK, 32'h3);
        xfer(1'b1, `LSC_OFF_ENABLE, 32'h1);
        #1 chk(32'(irq), 32'h1);
        rchk(`LSC_OFF_ENABLE, 32'h0);
        rchk(`LSC_OFF_ERROR, `LSC_ERR_CONFLICT);
        rchk(`LSC_OFF_ERROR, 32'h0);
        rchk(`LSC_OFF_IRQ_STATUS, 32'h2);
        repeat (2) @(posedge clk);
        #1 chk(32'(irq), 32'h0);
        xfer(1'b1, `LSC_OFF_IRQ_MASK, 32'h0);
        xfer(1'b1, `LSC_OFF_POINTS, 32'h0);
        #1 chk(32'(irq), 32'h0);
        rchk(`LSC_OFF_POINTS, 32'h1);
        rchk(`LSC_OFF_IRQ_STATUS, 32'h1);
        rchk(`LSC_OFF_ERROR, `LSC_ERR_CLIPPED);
        $display("test interlock done");
        // enabling under normal detector forces the coupled features off
        xfer(1'b1, `LSC_OFF_MODE, 32'h1);
        xfer(1'b1, `LSC_OFF_COUPLED, 32'h7F);
        rchk(`LSC_OFF_COUPLED, 32'h7F);
        xfer(1'b1, `LSC_OFF_ENABLE, 32'h1);
        rchk(`LSC_OFF_ENABLE, 32'h1);
        chk(32'(list_enable), 32'h1);
        rchk(`LSC_OFF_COUPLED, 32'h0);
        chk(32'({ccdf_sweep, ccdf_cont, trace_en, gate_auto}), 32'h0);
        // a running sequence blocks point count and enable writes
        seq_running <= 1'b1;
        xfer(1'b1, `LSC_OFF_POINTS, 32'h7);
        rchk(`LSC_OFF_POINTS, 32'h1);
        rchk(`LSC_OFF_ERROR, `LSC_ERR_CONFLICT);
        xfer(1'b1, `LSC_OFF_ENABLE, 32'h0);
        rchk(`LSC_OFF_ENABLE, 32'h1);
        seq_running <= 1'b0;
        xfer(1'b1, `LSC_OFF_ENABLE, 32'h0);
        rchk(`LSC_OFF_ENABLE, 32'h0);
        $display("test enable done");
        // count limits, reading count and frequency step
        xfer(1'b1, `LSC_OFF_POINTS, 32'h1388);
        rchk(`LSC_OFF_POINTS, 32'h1000);
        rchk(`LSC_OFF_ERROR, `LSC_ERR_CLIPPED);
        xfer(1'b1, `LSC_OFF_SLOTS, 32'h11);
        rchk(`LSC_OFF_SLOTS, 32'h10);
        xfer(1'b1, `LSC_OFF_POINTS, 32'hA);
        xfer(1'b1, `LSC_OFF_SLOTS, 32'h4);
        rchk(`LSC_OFF_READINGS, 32'h28);
        chk(32'(reading_count), 32'h28);
        chk(32'(point_count), 32'hA);
        chk(32'(slots_per_burst), 32'h4);
        xfer(1'b1, `LSC_OFF_SLOTS, 32'h0);
        rchk(`LSC_OFF_SLOTS, 32'h1);
        xfer(1'b1, `LSC_OFF_POINTS, 32'h9);
        // a division already under way with the old count finishes first, so allow two full runs
        repeat (70) @(posedge clk);
        rchk(`LSC_OFF_FREQ_STEP, 32'h1F4);
        freq_start <= 30'h0000_1388;
        freq_stop <= 30'h0000_03E8;
        repeat (40) @(posedge clk);
        #1 chk(32'(freq_step), 32'h1F4);
        $display("test counts done");
        // capture limit at its exact boundary, then rounding and clipping of times and percent
        xfer(1'b1, `LSC_OFF_SLOTS, 32'h10);
        xfer(1'b1, `LSC_OFF_SLOT_TIME, 32'h2FAF080);
        rchk(`LSC_OFF_SLOT_TIME, 32'h4C4B40);
        xfer(1'b1, `LSC_OFF_SLOT_TIME, 32'h2FAF08A);
        rchk(`LSC_OFF_SLOT_TIME, 32'h4C4B40);
        rchk(`LSC_OFF_ERROR, `LSC_ERR_CONFLICT);
        xfer(1'b1, `LSC_OFF_SLOTS, 32'h1);
        xfer(1'b1, `LSC_OFF_SLOT_TIME, 32'h0);
        rchk(`LSC_OFF_SLOT_TIME, 32'h1);
        xfer(1'b1, `LSC_OFF_EXCL_OFF, 32'hF);
        rchk(`LSC_OFF_EXCL_OFF, 32'h2);
        xfer(1'b1, `LSC_OFF_EXCL_OFF, 32'hE);
        rchk(`LSC_OFF_EXCL_OFF, 32'h1);
        xfer(1'b1, `LSC_OFF_EXCL_LEN, 32'h4C4B40A);
        rchk(`LSC_OFF_EXCL_LEN, 32'h7A1200);
        xfer(1'b1, `LSC_OFF_GATE_START, 32'h4D2);
        rchk(`LSC_OFF_GATE_START, 32'h7B);
        xfer(1'b1, `LSC_OFF_GATE_START, 32'h2715);
        rchk(`LSC_OFF_GATE_START, 32'h3E8);
        chk(32'(slot_duration), 32'h1);
        chk(32'(excl_off), 32'h1);
        chk(32'(excl_len), 32'h7A1200);
        chk(32'(gate_start), 32'h3E8);
        // average detector refuses every slot setting
        xfer(1'b1, `LSC_OFF_MODE, 32'h3);
        for (int i = 0; i < 5; i++) begin
            xfer(1'b0, offs[i], 32'h0);
            old = rd;
            xfer(1'b1, offs[i], 32'h14);
            rchk(offs[i], old);
            rchk(`LSC_OFF_ERROR, `LSC_ERR_CONFLICT);
        end
        $display("test slot timing done");
        summarize();
    end
endmodule : lsc_list_config_tb_top

`default_nettype wire
